/* File: include/exc_prio_pkg.sv */
// constants for the exception prioritisation block
// assumes one system clock and an active-low asynchronous system reset
`default_nettype none
package exc_prio_pkg;

    // ------------------------------------------------------------
    // vector map
    // ------------------------------------------------------------
    localparam int NUM_VECTORS = 48;
    localparam int VEC_W = 6;
    localparam int NUM_IRQ_LINES = 32;
    localparam logic [VEC_W-1:0] VEC_RESET = 6'h01;
    localparam logic [VEC_W-1:0] VEC_NMI = 6'h02;
    localparam logic [VEC_W-1:0] VEC_HARD_FAULT = 6'h03;
    localparam logic [VEC_W-1:0] VEC_SUPERVISOR_CALL = 6'h0b;
    localparam logic [VEC_W-1:0] VEC_PENDED_SERVICE = 6'h0e;
    localparam logic [VEC_W-1:0] VEC_SYSTEM_TICK = 6'h0f;
    localparam logic [VEC_W-1:0] VEC_IRQ_BASE = 6'h10;
    localparam logic [VEC_W-1:0] VEC_IRQ_LAST = 6'h2f;

    // ------------------------------------------------------------
    // fixed peripheral lines
    // ------------------------------------------------------------
    localparam int LINE_BROWNOUT = 0;
    localparam int LINE_WATCHDOG = 1;
    localparam int LINE_PIN_A = 2;
    localparam int LINE_PIN_B = 3;
    localparam int LINE_PORT_GROUP1 = 4;
    localparam int LINE_PORT_GROUP2 = 5;
    localparam int LINE_PWM_LOW = 6;
    localparam int LINE_PWM_HIGH = 7;
    localparam int LINE_OTHER_BASE = 8;
    localparam int NUM_OTHER_LINES = 24;
    localparam int PWM_CHANNELS = 8;
    localparam int PWM_HALF = 4;
    localparam int PORT_W = 16;
    localparam int PORT_B_W = 14;

    // ------------------------------------------------------------
    // priority ranks: lower is more urgent
    // ------------------------------------------------------------
    localparam int LEVEL_W = 2;
    localparam int RANK_W = 3;
    localparam logic [LEVEL_W-1:0] LEVEL_RESET_VALUE = 2'h0;
    localparam logic [RANK_W-1:0] RANK_RESET = 3'h0;
    localparam logic [RANK_W-1:0] RANK_NMI = 3'h1;
    localparam logic [RANK_W-1:0] RANK_HARD_FAULT = 3'h2;
    localparam logic [RANK_W-1:0] RANK_CFG_BASE = 3'h3;
    localparam logic [RANK_W-1:0] RANK_NONE = 3'h7;

endpackage

`default_nettype wire

/* File: logic/pend_cell.sv */
// one sticky pending flag
// assumes set and clear come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none

module pend_cell
#(
    parameter logic RESET_VALUE = 1'b0
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic set,
    input wire logic clear,
    output logic pend_next,
    output logic pend
);

    typedef struct packed {
        logic pend;
    } cell_state_type;

    cell_state_type s_reg;
    cell_state_type s_next;

    // ------------------------------------------------------------
    // set wins so a request in the ack cycle is kept
    // ------------------------------------------------------------
    always_comb
    begin
        s_next = s_reg;
        if (set)
        begin
            s_next.pend = 1'b1;
        end
        else if (clear)
        begin
            s_next.pend = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_reg.pend <= RESET_VALUE;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign pend_next = s_next.pend;
    assign pend = s_reg.pend;

endmodule

`default_nettype wire

/* File: logic/exception_priority_irq_map.sv */
// exception and interrupt prioritisation with fixed peripheral line map
// assumes all request inputs are on-chip and synchronous to clk
// Summary of operation
// - four configurable levels, 0 most urgent, 3 least urgent
// - every configurable level resets to 0 until written
// - reset, nmi, hard fault fixed at -3, -2, -1, above all levels
// - vectors 1,2,3 fixed; supervisor 11, pended service 14, tick 15
// - 32 peripheral lines, line n delivered as vector n plus 16
// - line 0 brown-out, line 1 watchdog
// - lines 2 and 3 carry the two external pin requests
// - line 4 ORs ports a and b, line 5 ORs ports c, d, e
// - line 6 ORs pwm channels 0-3, line 7 channels 4-7
`timescale 1ns/1ps
`default_nettype none

module exception_priority_irq_map
    import exc_prio_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic nmi_req,
    input wire logic hard_fault_req,
    input wire logic supervisor_call_exc,
    input wire logic pended_service_exc,
    input wire logic system_tick_exc,
    input wire logic brownout_irq,
    input wire logic watchdog_irq,
    input wire logic pin_irq_a,
    input wire logic pin_irq_b,
    input wire logic [PORT_W-1:0] port_a_irq,
    input wire logic [PORT_B_W-1:0] port_b_irq,
    input wire logic [PORT_W-1:0] port_c_irq,
    input wire logic [PORT_W-1:0] port_d_irq,
    input wire logic [PORT_W-1:0] port_e_irq,
    input wire logic [PWM_CHANNELS-1:0] pwm_ch_irq,
    input wire logic [NUM_OTHER_LINES-1:0] other_irq,
    input wire logic cfg_wr_en,
    input wire logic [VEC_W-1:0] cfg_wr_vector,
    input wire logic [LEVEL_W-1:0] cfg_wr_level,
    input wire logic exc_ack,
    output logic exc_valid,
    output logic [VEC_W-1:0] exc_vector,
    output logic [RANK_W-1:0] exc_rank
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // one level slot per vector; fixed and reserved slots are never written
    typedef struct packed {
        logic [NUM_VECTORS-1:0][LEVEL_W-1:0] level;
        logic valid;
        logic [VEC_W-1:0] vector;
        logic [RANK_W-1:0] rank;
    } ctrl_state_type;

    ctrl_state_type s_reg;
    ctrl_state_type s_next;
    logic [NUM_VECTORS-1:0] set_w;
    logic [NUM_VECTORS-1:0] clear_w;
    logic [NUM_VECTORS-1:0] pend_next_w;
    logic [NUM_IRQ_LINES-1:0] line_w;
    logic port_group1_irq;
    logic port_group2_irq;
    logic pwm_group_low_irq;
    logic pwm_group_high_irq;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // only the three configurable exceptions and the peripheral lines take a level
    function automatic logic is_configurable(input logic [VEC_W-1:0] v);
        return (v == VEC_SUPERVISOR_CALL) || (v == VEC_PENDED_SERVICE)
            || (v == VEC_SYSTEM_TICK) || ((v >= VEC_IRQ_BASE) && (v <= VEC_IRQ_LAST));
    endfunction

    // ------------------------------------------------------------
    // peripheral line map
    // ------------------------------------------------------------
    assign port_group1_irq = (|port_a_irq) | (|port_b_irq);
    assign port_group2_irq = (|port_c_irq) | (|port_d_irq) | (|port_e_irq);
    assign pwm_group_low_irq = |pwm_ch_irq[PWM_HALF-1:0];
    assign pwm_group_high_irq = |pwm_ch_irq[PWM_CHANNELS-1:PWM_HALF];

    // a held request level re-pends every cycle; the source must drop it
    always_comb
    begin
        line_w = '0;
        line_w[LINE_BROWNOUT] = brownout_irq;
        line_w[LINE_WATCHDOG] = watchdog_irq;
        line_w[LINE_PIN_A] = pin_irq_a;
        line_w[LINE_PIN_B] = pin_irq_b;
        line_w[LINE_PORT_GROUP1] = port_group1_irq;
        line_w[LINE_PORT_GROUP2] = port_group2_irq;
        line_w[LINE_PWM_LOW] = pwm_group_low_irq;
        line_w[LINE_PWM_HIGH] = pwm_group_high_irq;
        line_w[NUM_IRQ_LINES-1:LINE_OTHER_BASE] = other_irq;
    end

    // ------------------------------------------------------------
    // pending flags, one per vector
    // ------------------------------------------------------------
    always_comb
    begin
        set_w = '0;
        set_w[VEC_NMI] = nmi_req;
        set_w[VEC_HARD_FAULT] = hard_fault_req;
        set_w[VEC_SUPERVISOR_CALL] = supervisor_call_exc;
        set_w[VEC_PENDED_SERVICE] = pended_service_exc;
        set_w[VEC_SYSTEM_TICK] = system_tick_exc;
        set_w[VEC_IRQ_LAST:VEC_IRQ_BASE] = line_w;
    end

    // ------------------------------------------------------------
    // accept
    // ------------------------------------------------------------
    // only the presented vector is cleared, and only when accepted
    // an ack while nothing is shown clears nothing
    always_comb
    begin
        clear_w = '0;
        if (exc_ack && s_reg.valid)
        begin
            clear_w[s_reg.vector] = 1'b1;
        end
    end

    // reset vector comes out of reset already pending so the core fetches it first
    // reserved slots keep a cell so indexing stays flat; their set is tied low
    genvar gv;
    generate
        for (gv = 0; gv < NUM_VECTORS; gv++)
        begin : g_pend
            pend_cell #(
                .RESET_VALUE(gv == int'(VEC_RESET))
            ) u_pend (
                .clk(clk),
                .arst_n(arst_n),
                .set(set_w[gv]),
                .clear(clear_w[gv]),
                .pend_next(pend_next_w[gv]),
                .pend()
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // level writes and selection
    // ------------------------------------------------------------
    always_comb
    begin
        logic [RANK_W-1:0] r;
        logic [RANK_W-1:0] best_rank;
        logic [VEC_W-1:0] best_vec;
        r = RANK_NONE;
        best_rank = RANK_NONE;
        best_vec = '0;
        s_next = s_reg;
        // writes to fixed or reserved vectors are dropped
        // the ranking below still reads the old level, so a write shows a cycle later
        if (cfg_wr_en && is_configurable(cfg_wr_vector))
        begin
            s_next.level[cfg_wr_vector] = cfg_wr_level;
        end
        // picked from next pending so an accepted vector is never shown twice
        for (int v = 0; v < NUM_VECTORS; v++)
        begin
            if (VEC_W'(v) == VEC_RESET)
            begin
                r = RANK_RESET;
            end
            else if (VEC_W'(v) == VEC_NMI)
            begin
                r = RANK_NMI;
            end
            else if (VEC_W'(v) == VEC_HARD_FAULT)
            begin
                r = RANK_HARD_FAULT;
            end
            else
            begin
                // levels 0 to 3 sit just past the three fixed ranks
                r = RANK_CFG_BASE + RANK_W'(s_reg.level[v]);
            end
            // no masking: every pending flag competes each cycle
            // strict compare keeps the lowest vector on a tie
            if (pend_next_w[v] && (r < best_rank))
            begin
                best_rank = r;
                best_vec = VEC_W'(v);
            end
        end
        s_next.valid = (best_rank != RANK_NONE);
        s_next.vector = best_vec;
        s_next.rank = best_rank;
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s_reg.level <= {NUM_VECTORS{LEVEL_RESET_VALUE}};
            s_reg.valid <= 1'b0;
            s_reg.vector <= '0;
            s_reg.rank <= RANK_NONE;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // all three come straight from flops, so the core never sees a glitch
    assign exc_valid = s_reg.valid;
    assign exc_vector = s_reg.vector;
    assign exc_rank = s_reg.rank;

endmodule

`default_nettype wire

/* File: sim/exc_prio_monitor.sv */
// assertions on the prioritiser's request and vector ports
// assumes one clock domain and binding to the top module
`timescale 1ns/1ps
`default_nettype none
module exc_prio_monitor
    import exc_prio_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic nmi_req,
    input wire logic hard_fault_req,
    input wire logic [PWM_CHANNELS-1:0] pwm_ch_irq,
    input wire logic exc_ack,
    input wire logic exc_valid,
    input wire logic [VEC_W-1:0] exc_vector,
    input wire logic [RANK_W-1:0] exc_rank
);
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    property p_boot; $rose(arst_n) |=> exc_valid && exc_vector == VEC_RESET; endproperty
    a_boot: assert property (p_boot) else $error("reset vector not first");
    property p_nmi; nmi_req |=> exc_valid && exc_rank <= RANK_NMI; endproperty
    a_nmi: assert property (p_nmi) else $error("nmi not presented");
    property p_hard; hard_fault_req |=> exc_valid && exc_rank <= RANK_HARD_FAULT; endproperty
    a_hard: assert property (p_hard) else $error("hard fault not presented");
    property p_fixed; exc_valid && exc_vector <= VEC_HARD_FAULT |->
        exc_rank == RANK_W'(exc_vector - 6'h01); endproperty
    a_fixed: assert property (p_fixed) else $error("fixed rank wrong");
    property p_cfg; exc_valid && exc_vector > VEC_HARD_FAULT |->
        exc_rank >= RANK_CFG_BASE && exc_rank <= 3'h6; endproperty
    a_cfg: assert property (p_cfg) else $error("configurable rank out of range");
    property p_map; exc_valid |->
        exc_vector inside {[6'h01:6'h03], 6'h0b, [6'h0e:6'h2f]}; endproperty
    a_map: assert property (p_map) else $error("reserved vector presented");
    property p_hold; exc_valid && !exc_ack |=> exc_valid; endproperty
    a_hold: assert property (p_hold) else $error("pending lost without ack");
    property p_pwm; (|pwm_ch_irq) |=> exc_valid; endproperty
    a_pwm: assert property (p_pwm) else $error("pwm request not presented");
endmodule
bind exception_priority_irq_map exc_prio_monitor mon_u (.clk, .arst_n, .nmi_req,
    .hard_fault_req, .pwm_ch_irq, .exc_ack, .exc_valid, .exc_vector, .exc_rank);
`default_nettype wire

/* File: sim/core_model.sv */
// behavioural core accepting whatever vector is presented
// assumes stall comes from the bench on the same clock
`timescale 1ns/1ps
`default_nettype none
module core_model
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic stall,
    input wire logic exc_valid,
    output logic exc_ack
);
    // stall models a busy core so that several requests pile up
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            exc_ack <= 1'b0;
        else
            exc_ack <= exc_valid && !stall;
    end
endmodule
`default_nettype wire

/* File: sim/test_exception_priority_irq_map.sv */
// self-checking bench: requests in, acked vectors compared from a queue
// assumes core_model answers and the monitor is bound to the design
`timescale 1ns/1ps
`default_nettype none
module test_exception_priority_irq_map;
    import exc_prio_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic stall = 1'b0;
    logic nmi_req, hard_fault_req, supervisor_call_exc, pended_service_exc;
    logic system_tick_exc, brownout_irq, watchdog_irq, pin_irq_a, pin_irq_b;
    logic [29:0] grp1;
    logic [47:0] grp2;
    logic [PWM_CHANNELS-1:0] pwm_ch_irq;
    logic [NUM_OTHER_LINES-1:0] other_irq;
    logic cfg_wr_en, exc_ack, exc_valid;
    logic [VEC_W-1:0] cfg_wr_vector, exc_vector;
    logic [LEVEL_W-1:0] cfg_wr_level;
    logic [RANK_W-1:0] exc_rank;
    logic [8:0] expq[$];
    logic [8:0] exp_now;
    int mismatches = 0;
    int check_count = 0;
    int prio_set[6] = '{0, 2, 5, 6, 7, 8};
    logic [8:0] prio_exp[6] = '{{6'h02, 3'h1}, {6'h12, 3'h3}, {6'h13, 3'h3},
        {6'h11, 3'h4}, {6'h0b, 3'h5}, {6'h10, 3'h6}};
    always #10 clk = ~clk;
    exception_priority_irq_map dut_u (.clk, .arst_n, .nmi_req, .hard_fault_req,
        .supervisor_call_exc, .pended_service_exc, .system_tick_exc, .brownout_irq,
        .watchdog_irq, .pin_irq_a, .pin_irq_b, .port_a_irq(grp1[15:0]),
        .port_b_irq(grp1[29:16]), .port_c_irq(grp2[15:0]), .port_d_irq(grp2[31:16]),
        .port_e_irq(grp2[47:32]), .pwm_ch_irq, .other_irq, .cfg_wr_en, .cfg_wr_vector,
        .cfg_wr_level, .exc_ack, .exc_valid, .exc_vector, .exc_rank);
    core_model core_u (.clk, .arst_n, .stall, .exc_valid, .exc_ack);
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic clear_all();
        {nmi_req, hard_fault_req, supervisor_call_exc, pended_service_exc} = '0;
        {system_tick_exc, brownout_irq, watchdog_irq, pin_irq_a, pin_irq_b} = '0;
        {grp1, grp2, pwm_ch_irq, other_irq, cfg_wr_en, cfg_wr_vector, cfg_wr_level} = '0;
    endtask
    task automatic fire(input int i);
        case (i)
            0: nmi_req = 1'b1;
            1: hard_fault_req = 1'b1;
            2: supervisor_call_exc = 1'b1;
            3: pended_service_exc = 1'b1;
            4: system_tick_exc = 1'b1;
            5: brownout_irq = 1'b1;
            6: watchdog_irq = 1'b1;
            7: pin_irq_a = 1'b1;
            8: pin_irq_b = 1'b1;
            9: grp1[$urandom_range(29)] = 1'b1;
            10: grp2[$urandom_range(47)] = 1'b1;
            11: pwm_ch_irq[$urandom_range(3)] = 1'b1;
            12: pwm_ch_irq[4 + $urandom_range(3)] = 1'b1;
            default: other_irq[i - 13] = 1'b1;
        endcase
    endtask
    function automatic logic [8:0] expect_of(input int i);
        logic [VEC_W-1:0] v;
        v = (i == 2) ? VEC_SUPERVISOR_CALL : (i == 3) ? VEC_PENDED_SERVICE : VEC_SYSTEM_TICK;
        if (i < 2)
            return {VEC_NMI + VEC_W'(i), RANK_NMI + RANK_W'(i)};
        if (i > 4)
            v = VEC_IRQ_BASE + VEC_W'(i - 5);
        return {v, RANK_CFG_BASE};
    endfunction
    task automatic check_exc(input logic [8:0] exp, input logic [8:0] seen);
        check_count++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR exc vector/rank expected %h seen %h", exp, seen);
        end
    endtask
    // a stuck queue means an expected vector never got acked
    task automatic drain();
        repeat (40)
            if (expq.size() != 0)
                @(negedge clk);
        check_exc(9'h000, 9'(expq.size()));
        expq.delete();
    endtask
    task automatic pulse(input int i);
        fire(i);
        expq.push_back(expect_of(i));
        @(negedge clk);
        clear_all();
        drain();
    endtask
    task automatic cfg(input logic [VEC_W-1:0] v, input logic [LEVEL_W-1:0] l);
        {cfg_wr_en, cfg_wr_vector, cfg_wr_level} = {1'b1, v, l};
        @(negedge clk);
        cfg_wr_en = 1'b0;
        @(negedge clk);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // checking and stimulus
    // ----------------------------------------
    // looked at mid-cycle, where valid, ack and vector are settled for the next edge
    always @(negedge clk)
    begin
        if (arst_n === 1'b1 && exc_valid === 1'b1 && exc_ack === 1'b1)
        begin
            exp_now = (expq.size() != 0) ? expq.pop_front() : 9'h1ff;
            check_exc(exp_now, {exc_vector, exc_rank});
        end
    end
    initial
    begin
        #100000;
        mismatches++;
        stop_test();
    end
    initial
    begin
        clear_all();
        void'($urandom(5638));
        expq.push_back({VEC_RESET, RANK_RESET});
        repeat (8) @(negedge clk);
        arst_n = 1'b1;
        drain();
        for (int i = 0; i < 37; i++)
            pulse(i);
        stall = 1'b1;
        cfg(6'h10, 2'h3);
        cfg(6'h11, 2'h1);
        cfg(6'h0b, 2'h2);
        cfg(6'h0c, 2'h0);
        foreach (prio_set[k])
            fire(prio_set[k]);
        foreach (prio_exp[k])
            expq.push_back(prio_exp[k]);
        @(negedge clk);
        clear_all();
        stall = 1'b0;
        drain();
        stop_test();
    end
endmodule
`default_nettype wire
